// File: hw/rxp_ctrl.sv
// Self-polling sleep, start-up and bit-check controller with APB registers.
// What this block does
// - Base tick comes from dividing the crystal clock by 28 or 30.
// - Extended tick is 8, 4, 2 or 1 base ticks per rate band.
// - Polling cycles sleep, start-up, bit check; a failed check returns to sleep.
// - Sleep keeps processing off for the programmed sleep span unless force-on goes low, which ends it early and leaves the sleep count uncleared.
// - Start-up enables processing; its length depends on rate band and base tick.
// - Demodulator edges are ignored until start-up has finished.
// - Active indicator is low in sleep and high in start-up, bit check and receiving mode.
// - Sleep span equals sleep count times stretch times 1024 base ticks.
// - Stretch factor is 8 when stretch select is one, else 1.
// - Maximum sleep count means permanent sleep until another count is written.
// - In permanent sleep the force-on pin switches the receiver on; releasing it returns to sleep only from start-up or bit check.
// - Check bit field selects 0, 3, 6 or 9 bits, meaning 0, 6, 12, 18 checks.
// - After all configured intervals pass, the block enters receiving mode.
// - Interval counter advances per extended tick and restarts at each edge.
// - Edge while counter is below the low limit fails the check.
// - Counter reaching the high limit before an edge fails the check.
// - Low window is low limit ticks; high window is high limit minus one ticks.
// - Low and high limits are 5-bit fields of the limit register.
// - Receiving mode holds until software commands a return to polling.
// - Force-on low goes to start-up regardless of settings, which stay stored.
`timescale 1ns/1ns
`default_nettype none
module rxp_ctrl #(
    parameter int DIVIDER = rxp_pkg::DIV_A
) (
    // Clock and reset.
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    // APB slave.
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Receiver side.
    input  wire logic        I_DEM_OUT,
    input  wire logic        I_FORCE_ON_N,
    output logic             O_ACTIVE_INDICATOR,
    output logic             O_RECEIVING,
    output logic             O_DATA
);
    import rxp_pkg::*;

    rxp_operation_config_reg_t op;
    rxp_limit_t  lim;
    rxp_state_t  state;
    logic [4:0]  base_cnt;
    logic        base_tick;
    logic [2:0]  xdiv;
    logic        extended_tick;
    logic [17:0] sleep_cnt;
    logic [17:0] sleep_span;
    logic [5:0]  warm_cnt;
    logic [5:0]  interval_counter;
    logic [4:0]  checks_done;
    logic [4:0]  checks_need;
    logic        dem_sync;
    logic        edge_seen;
    logic        wr;
    logic        poll_cmd;
    logic        perm_sleep;
    logic        force_on;

    function automatic logic [2:0] band_div(input logic [1:0] band);
        unique case (band)
            2'h0:    band_div = BAND_DIV0;
            2'h1:    band_div = BAND_DIV1;
            2'h2:    band_div = BAND_DIV2;
            default: band_div = BAND_DIV3;
        endcase
    endfunction

    assign wr         = I_PSEL && I_PENABLE && I_PWRITE;
    assign poll_cmd   = wr && I_PADDR == ADDR_OPERATION_CONFIG_REG && I_PWDATA[OP_POLL_CMD];
    assign force_on   = !I_FORCE_ON_N;
    assign perm_sleep = op.sleep_count == SLEEP_MAX;
    assign O_PREADY   = 1'b1;
    assign O_PSLVERR  = I_PSEL && I_PENABLE && I_PADDR != ADDR_OPERATION_CONFIG_REG && I_PADDR != ADDR_LIMIT
                        && I_PADDR != ADDR_STATUS;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            op  <= '{SLEEP_RST, 1'b0, 2'h0, NBIT_RST};
            lim <= '{LIM_MAX_RST, LIM_MIN_RST};
        end else if (wr && I_PADDR == ADDR_OPERATION_CONFIG_REG) begin
            op.sleep_count          <= I_PWDATA[OP_SLEEP_LSB +: 5];
            op.sleep_stretch_select <= I_PWDATA[OP_STRETCH];
            op.rate_band            <= I_PWDATA[OP_BAND_LSB +: 2];
            op.check_bits           <= I_PWDATA[OP_NBIT_LSB +: 2];
        end else if (wr && I_PADDR == ADDR_LIMIT) begin
            lim.lim_min <= I_PWDATA[LIM_MIN_LSB +: 5];
            lim.lim_max <= I_PWDATA[LIM_MAX_LSB +: 5];
        end
    end

    always_comb begin
        O_PRDATA = 32'h0;
        unique case (I_PADDR)
            ADDR_OPERATION_CONFIG_REG: O_PRDATA[9:0] = {op.check_bits, op.rate_band, op.sleep_stretch_select, op.sleep_count};
            ADDR_LIMIT:  O_PRDATA[12:0] = {lim.lim_max, 3'h0, lim.lim_min};
            ADDR_STATUS: O_PRDATA[9:0] = {checks_done, 1'b0, state};
            default:     O_PRDATA = 32'h0;
        endcase
    end

    // Base tick divider.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            base_cnt <= 5'h0;
        end else if (base_tick) begin
            base_cnt <= 5'h0;
        end else begin
            base_cnt <= base_cnt + 5'h1;
        end
    end
    assign base_tick = base_cnt == 5'(DIVIDER - 1);

    // Extended tick prescaler.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            xdiv <= 3'h0;
        end else if (extended_tick) begin
            xdiv <= 3'h0;
        end else if (base_tick) begin
            xdiv <= xdiv + 3'h1;
        end
    end
    assign extended_tick = base_tick && xdiv >= band_div(op.rate_band);

    // Sleep span in base ticks.
    assign sleep_span = 18'(op.sleep_count * (op.sleep_stretch_select ? STRETCH_ON : STRETCH_OFF) * SLEEP_UNIT);

    always_comb begin
        unique case (op.check_bits)
            2'h0:    checks_need = CHECKS_NONE;
            2'h1:    checks_need = CHECKS_3BIT;
            2'h2:    checks_need = CHECKS_6BIT;
            default: checks_need = CHECKS_9BIT;
        endcase
    end

    // Demodulator sampled on the extended tick.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            dem_sync <= 1'b0;
        end else if (extended_tick) begin
            dem_sync <= I_DEM_OUT;
        end
    end
    assign edge_seen = extended_tick && (I_DEM_OUT != dem_sync);
    assign O_DATA    = state == RXP_RECEIVE ? dem_sync : 1'b1;

    // Polling state machine.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state            <= RXP_SLEEP;
            sleep_cnt        <= 18'h0;
            warm_cnt         <= 6'h0;
            interval_counter <= 6'h0;
            checks_done      <= 5'h0;
        end else begin
            unique case (state)
                RXP_SLEEP: begin
                    if (force_on) begin
                        state    <= RXP_STARTUP;
                        warm_cnt <= 6'h0;
                    end else if (!perm_sleep && base_tick) begin
                        if (sleep_cnt + 18'h1 >= sleep_span) begin
                            state     <= RXP_STARTUP;
                            sleep_cnt <= 18'h0;
                            warm_cnt  <= 6'h0;
                        end else begin
                            sleep_cnt <= sleep_cnt + 18'h1;
                        end
                    end
                end
                RXP_STARTUP: begin
                    if (perm_sleep && !force_on) begin
                        state <= RXP_SLEEP;
                    end else if (extended_tick) begin
                        if (warm_cnt == WARM_TICKS - 6'h1) begin
                            interval_counter <= 6'h1;
                            checks_done      <= 5'h0;
                            state <= (force_on || checks_need == 5'h0) ? RXP_RECEIVE : RXP_CHECK;
                        end else begin
                            warm_cnt <= warm_cnt + 6'h1;
                        end
                    end
                end
                RXP_CHECK: begin
                    if (perm_sleep && !force_on) begin
                        state <= RXP_SLEEP;
                    end else if (edge_seen) begin
                        interval_counter <= 6'h1;
                        if (interval_counter < 6'(lim.lim_min)) begin
                            state <= RXP_SLEEP;
                        end else if (checks_done + 5'h1 >= checks_need) begin
                            state <= RXP_RECEIVE;
                        end else begin
                            checks_done <= checks_done + 5'h1;
                        end
                    end else if (extended_tick) begin
                        if (interval_counter + 6'h1 >= 6'(lim.lim_max)) begin
                            state <= RXP_SLEEP;
                        end else begin
                            interval_counter <= interval_counter + 6'h1;
                        end
                    end
                end
                RXP_RECEIVE: begin
                    if (poll_cmd) begin
                        state     <= RXP_SLEEP;
                        sleep_cnt <= 18'h0;
                    end
                end
                default: state <= RXP_SLEEP;
            endcase
        end
    end

    assign O_ACTIVE_INDICATOR = state != RXP_SLEEP;
    assign O_RECEIVING        = state == RXP_RECEIVE;

    a_sleep_quiet: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        !O_ACTIVE_INDICATOR
        |-> !O_RECEIVING && O_DATA) else $error("active outputs in sleep");

    a_perm_sleep: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_SLEEP && perm_sleep && !force_on
        |=> state == RXP_SLEEP) else $error("left permanent sleep");

    a_force_wake: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_SLEEP && force_on
        |=> state == RXP_STARTUP) else $error("force-on ignored");

    a_short_fail: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_CHECK && !(perm_sleep && !force_on) && edge_seen && interval_counter < 6'(lim.lim_min)
        |=> state == RXP_SLEEP) else $error("short interval passed");

    a_long_fail: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_CHECK
        |-> interval_counter < 6'(lim.lim_max)) else $error("counter beyond high limit");

    a_edge_restart: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_CHECK && !(perm_sleep && !force_on) && edge_seen
        |=> interval_counter == 6'h1) else $error("counter not restarted");

    a_receive_hold: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_RECEIVE && !poll_cmd
        |=> state == RXP_RECEIVE) else $error("left receive mode");

    a_tick_spacing: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        base_tick
        |=> !base_tick [*8]) else $error("base tick too often");

    a_startup_gate: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_SLEEP ##1 state == RXP_STARTUP
        |-> warm_cnt == 6'h0) else $error("warm-up not restarted");

    a_base_wrap: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        base_tick
        |=> base_cnt == 5'h0) else $error("base divider not restarted");

    a_ext_on_base: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        extended_tick
        |-> base_tick) else $error("extended tick off the base tick");

    a_ext_band3: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        op.rate_band == 2'h3 && base_tick
        |-> extended_tick) else $error("fastest band skipped a tick");

    a_ext_band0: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        op.rate_band == 2'h0 && extended_tick
        |-> xdiv == 3'h7) else $error("slowest band tick too early");

    a_sleep_hold: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_SLEEP && !force_on && !base_tick
        |=> state == RXP_SLEEP) else $error("left sleep between ticks");

    a_sleep_step: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_SLEEP && !force_on && !perm_sleep && base_tick && sleep_cnt + 18'h1 < sleep_span
        |=> state == RXP_SLEEP && sleep_cnt == $past(sleep_cnt) + 18'h1) else $error("sleep count not advanced");

    a_sleep_end: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_SLEEP && !force_on && !perm_sleep && base_tick && sleep_cnt + 18'h1 >= sleep_span
        |=> state == RXP_STARTUP) else $error("sleep span overrun");

    a_warm_count: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_STARTUP && !(perm_sleep && !force_on) && extended_tick && warm_cnt != WARM_TICKS - 6'h1
        |=> state == RXP_STARTUP) else $error("start-up cut short");

    a_warm_end: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_STARTUP && !(perm_sleep && !force_on) && extended_tick && warm_cnt == WARM_TICKS - 6'h1
        |=> state == RXP_CHECK || state == RXP_RECEIVE) else $error("start-up did not end");

    a_no_early_fail: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_STARTUP && !(perm_sleep && !force_on)
        |=> state != RXP_SLEEP) else $error("edge judged during start-up");

    a_zero_checks: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_STARTUP && !(perm_sleep && !force_on) && extended_tick && warm_cnt == WARM_TICKS - 6'h1
        && checks_need == CHECKS_NONE
        |=> state == RXP_RECEIVE) else $error("zero checks not direct");

    a_check_pass: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_CHECK && !(perm_sleep && !force_on) && edge_seen && interval_counter >= 6'(lim.lim_min)
        && checks_done + 5'h1 >= checks_need
        |=> state == RXP_RECEIVE) else $error("receive not entered");

    a_check_count: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_CHECK && !(perm_sleep && !force_on) && edge_seen && interval_counter >= 6'(lim.lim_min)
        && checks_done + 5'h1 < checks_need
        |=> state == RXP_CHECK && checks_done == $past(checks_done) + 5'h1) else $error("check not counted");

    a_tick_advance: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_CHECK && !(perm_sleep && !force_on) && !edge_seen && extended_tick && interval_counter + 6'h1 < 6'(lim.lim_max)
        |=> interval_counter == $past(interval_counter) + 6'h1) else $error("interval not advanced");

    a_count_still: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_CHECK && !extended_tick
        |=> $stable(interval_counter)) else $error("interval moved between ticks");

    a_long_end: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_CHECK && !(perm_sleep && !force_on) && !edge_seen && extended_tick && interval_counter + 6'h1 >= 6'(lim.lim_max)
        |=> state == RXP_SLEEP) else $error("long interval passed");

    a_force_follow: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (state == RXP_STARTUP || state == RXP_CHECK) && perm_sleep && !force_on
        |=> state == RXP_SLEEP) else $error("force-on release ignored");

    a_poll_return: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_RECEIVE && poll_cmd
        |=> state == RXP_SLEEP) else $error("poll command ignored");

    a_data_idle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state != RXP_RECEIVE
        |-> O_DATA) else $error("data driven outside receive");

    a_check_bound: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        state == RXP_CHECK
        |-> checks_done < checks_need) else $error("too many checks");

    a_lim_write: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        wr && I_PADDR == ADDR_LIMIT
        |=> lim.lim_min == $past(I_PWDATA[LIM_MIN_LSB +: 5])) else $error("low limit not stored");
endmodule
`default_nettype wire

// File: hw/rxp_pkg.sv
// Package with constants and types of the receiver polling controller.
package rxp_pkg;

    // Register byte offsets.
    localparam logic [7:0] ADDR_OPERATION_CONFIG_REG = 8'h00;
    localparam logic [7:0] ADDR_LIMIT  = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // Field positions in the operation configuration register.
    localparam int OP_SLEEP_LSB  = 0;
    localparam int OP_STRETCH    = 5;
    localparam int OP_BAND_LSB   = 6;
    localparam int OP_NBIT_LSB   = 8;
    localparam int OP_POLL_CMD   = 10;

    // Field positions in the limit register.
    localparam int LIM_MIN_LSB = 0;
    localparam int LIM_MAX_LSB = 8;

    // Reset values.
    localparam logic [4:0] SLEEP_RST   = 5'h1f;
    localparam logic [4:0] LIM_MIN_RST = 5'h0e;
    localparam logic [4:0] LIM_MAX_RST = 5'h18;
    localparam logic [1:0] NBIT_RST    = 2'h1;

    // Timing constants.
    localparam int          DIV_A       = 28;
    localparam int          DIV_B       = 30;
    localparam logic [10:0] SLEEP_UNIT  = 11'h400;
    localparam logic [3:0]  STRETCH_ON  = 4'h8;
    localparam logic [3:0]  STRETCH_OFF = 4'h1;
    localparam logic [4:0]  SLEEP_MAX   = 5'h1f;
    localparam logic [5:0]  WARM_TICKS  = 6'h20;
    localparam logic [2:0]  BAND_DIV0   = 3'h7;
    localparam logic [2:0]  BAND_DIV1   = 3'h3;
    localparam logic [2:0]  BAND_DIV2   = 3'h1;
    localparam logic [2:0]  BAND_DIV3   = 3'h0;
    localparam logic [4:0]  CHECKS_NONE = 5'h00;
    localparam logic [4:0]  CHECKS_3BIT = 5'h06;
    localparam logic [4:0]  CHECKS_6BIT = 5'h0c;
    localparam logic [4:0]  CHECKS_9BIT = 5'h12;

    typedef enum logic [3:0] {
        RXP_SLEEP   = 4'b0001,
        RXP_STARTUP = 4'b0010,
        RXP_CHECK   = 4'b0100,
        RXP_RECEIVE = 4'b1000
    } rxp_state_t;

    typedef struct packed {
        logic [4:0] sleep_count;
        logic       sleep_stretch_select;
        logic [1:0] rate_band;
        logic [1:0] check_bits;
    } rxp_operation_config_reg_t;

    typedef struct packed {
        logic [4:0] lim_max;
        logic [4:0] lim_min;
    } rxp_limit_t;

endpackage

// File: testbench/rxp_mcu_model.sv
// Microcontroller model: APB master and force-on pin driver.
`timescale 1ns/1ns
`default_nettype none
module rxp_mcu_model (
    // Clock.
    input  wire logic        i_clk,
    // APB master.
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr,
    // Force-on pin, active low.
    output logic             o_force_on_n
);
    import rxp_pkg::*;
    initial begin
        {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
        o_force_on_n = 1'b1;
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge i_clk);
        {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge i_clk);
        o_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (i_pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            tb.err_total++;
            tb.wrap_up();
        end
        q = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask
    // Six checks with the default limits 14 and 24; count 31 when polling only by force-on.
    task automatic cfg(input logic [4:0] sl, input logic cmd);
        logic [31:0] q;
        logic        e;
        apb(1'b1, ADDR_OPERATION_CONFIG_REG, {21'h0, cmd, 2'b01, 2'b11, 1'b0, sl}, q, e);
    endtask
    task automatic force_pin(input logic v);
        @(posedge i_clk);
        o_force_on_n <= v;
    endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking testbench of the receiver polling controller.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import rxp_pkg::*;
    localparam int XT   = DIV_A;
    localparam int WARM = 32 * XT;
    localparam int SLP  = 1024 * DIV_A;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        dem, force_n, act, rx, dout, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    int          err_total, n_tests, n;
    rxp_ctrl #(.DIVIDER(DIV_A)) rxp_ctrl_inst (.I_CLK(clk), .I_RSTN(rst_n), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_DEM_OUT(dem),
        .I_FORCE_ON_N(force_n), .O_ACTIVE_INDICATOR(act), .O_RECEIVING(rx), .O_DATA(dout));
    rxp_mcu_model rxp_mcu_model_inst (.i_clk(clk), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
        .i_pready(pready), .i_pslverr(pslverr), .o_force_on_n(force_n));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    // Waits a bounded number of cycles for the active or receiving output to reach a level.
    task automatic wait_for(input logic want_rx, input logic v, input int lim, output int cnt);
        cnt = 0;
        while ((want_rx ? rx : act) !== v) begin
            @(posedge clk);
            cnt++;
            if (cnt > lim) begin
                chk(32'(~v), 32'(v));
                wrap_up();
            end
        end
    endtask
    task automatic rd(input logic [7:0] a);
        rxp_mcu_model_inst.apb(1'b0, a, 32'h0, q, e);
    endtask
    task automatic t_reset();
        chk({29'h0, act, rx, dout}, 32'h1);
        rd(ADDR_OPERATION_CONFIG_REG);
        chk(q, 32'h0000011f);
        rd(ADDR_LIMIT);
        chk(q, 32'h0000180e);
        rd(8'h0c);
        chk({q[30:0], e}, 32'h1);
    endtask
    task automatic t_force();
        rxp_mcu_model_inst.cfg(5'h1f, 1'b0);
        n = 0;
        repeat (2000) begin
            @(posedge clk);
            n += int'(act !== 1'b0);
        end
        chk(32'(n), 32'h0);
        rxp_mcu_model_inst.force_pin(1'b0);
        wait_for(1'b0, 1'b1, 3, n);
        wait_for(1'b1, 1'b1, WARM + 2 * XT, n);
        chk(32'(n >= WARM - XT), 32'h1);
        rxp_mcu_model_inst.force_pin(1'b1);
        repeat (50) @(posedge clk);
        chk(32'(rx), 32'h1);
        rxp_mcu_model_inst.cfg(5'h1f, 1'b1);
        wait_for(1'b0, 1'b0, 4, n);
        rd(ADDR_OPERATION_CONFIG_REG);
        chk(q & 32'h3ff, 32'h1df);
    endtask
    // A steady demodulator lets the interval counter run into the high limit.
    task automatic t_timeout();
        rxp_mcu_model_inst.cfg(5'h01, 1'b0);
        wait_for(1'b0, 1'b1, SLP + 4 * XT, n);
        wait_for(1'b0, 1'b0, WARM + 26 * XT, n);
        chk(32'(n >= WARM + 21 * XT), 32'h1);
        wait_for(1'b0, 1'b1, SLP + 2 * XT, n);
        chk(32'(n >= SLP - XT), 32'h1);
    endtask
    task automatic t_fast();
        repeat (WARM + XT / 2) @(posedge clk);
        repeat (4) begin
            dem <= ~dem;
            repeat (5 * XT) @(posedge clk);
        end
        chk({30'h0, act, rx}, 32'h0);
    endtask
    // Edges every 20 extended ticks sit inside the 14 to 23 window.
    task automatic t_pass();
        int edges;
        edges = 0;
        wait_for(1'b0, 1'b1, SLP + 2 * XT, n);
        repeat (WARM + XT / 2) @(posedge clk);
        while (rx !== 1'b1 && edges < 10) begin
            repeat (18 * XT) @(posedge clk);
            dem <= ~dem;
            edges++;
            repeat (2 * XT) @(posedge clk);
        end
        chk(32'(edges >= 6 && edges <= 7 && rx === 1'b1), 32'h1);
        dem <= 1'b0;
        repeat (3 * XT) @(posedge clk);
        chk({30'h0, rx, dout}, 32'h2);
    endtask
    // Zero check bits: receive follows start-up with no edges at all.
    task automatic t_direct();
        rxp_mcu_model_inst.apb(1'b1, ADDR_OPERATION_CONFIG_REG, {21'h0, 1'b1, 2'b00, 2'b11, 1'b0, 5'h01}, q, e);
        wait_for(1'b0, 1'b0, 4, n);
        wait_for(1'b1, 1'b1, SLP + WARM + 4 * XT, n);
        chk(32'(n >= SLP + WARM - 2 * XT), 32'h1);
        chk({31'h0, act}, 32'h1);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        dem = 1'b1;
        err_total = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_force();
        t_timeout();
        t_fast();
        t_pass();
        t_direct();
        wrap_up();
    end
endmodule
`default_nettype wire
